// ==== rtl/fbh_host.sv ====
// Host controller that drives a boot-block flash over its parallel bus pins.
module fbh_host
    import fbh_pkg::*;
#(
    parameter int ACCESS_CYCLES = ACCESS_DEFAULT
) (
    // Clock and reset.
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    // User request side.
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire fbh_req_type            req,
    input  wire logic                   byte_mode,
    input  wire logic                   protect_n,
    output logic                        rsp_valid,
    output logic [DATA_W-1:0]           rsp_data,
    output logic [5:0]                  rsp_block_kind,
    output fbh_mode_type                cur_mode,
    // Device pins.
    output fbh_ctl_type                 ctl,
    output logic [WORD_ADDR_W-1:0]      addr_pins,
    output logic                        addr_low,
    input  wire logic [DATA_W-1:0]      data_pins_in,
    output logic [DATA_W-1:0]           data_pins_out,
    output logic                        data_pins_oe_n
);

    // Controller states.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCESS = 2'b01,
        ST_RESET  = 2'b10,
        ST_DONE   = 2'b11
    } fbh_state_type;

    fbh_state_type     state_reg, state_next;   // Sequencer state.
    fbh_req_type       cur_reg;                 // Captured request.
    logic [7:0]        cnt_reg;                 // Phase cycle counter.
    fbh_mode_type      mode_reg;                // Read mode the device is believed to be in.
    logic [DATA_W-1:0] rdata_reg;               // Captured read data.
    logic              rsp_reg;                 // Response pulse.

    // Decoded phase conditions.
    wire is_read    = (cur_reg.op == OP_READ);
    wire is_write   = (cur_reg.op == OP_WRITE) || (cur_reg.op == OP_MODE);
    wire in_access  = (state_reg == ST_ACCESS);
    wire in_reset   = (state_reg == ST_RESET);
    wire last_cycle = (cnt_reg == 8'h00);
    wire [7:0] access_len = 8'(ACCESS_CYCLES - 1);
    wire [7:0] reset_len  = 8'(RESET_CYCLES - 1);

    // Request the pins follow: the incoming one on the edge it is taken, the held one after.
    // This keeps address and write data valid from the same edge that lowers chip select.
    wire              take_now = req_ready && req_valid;      // A request is accepted on this edge.
    wire fbh_req_type src_req  = take_now ? req : cur_reg;    // Request seen by the pin logic.

    // Mode command byte chosen from the requested mode.
    wire [7:0] mode_cmd = (src_req.mode == MODE_IDENT)  ? CMD_READ_IDENT :
                          (src_req.mode == MODE_STATUS) ? CMD_READ_STATUS : CMD_READ_ARRAY;

    // Word address: in byte mode the low line picks the byte, so drop it.
    wire [WORD_ADDR_W-1:0] word_addr = byte_mode ? src_req.addr[BYTE_ADDR_W-1:1]
                                                 : src_req.addr[WORD_ADDR_W-1:0];

    // Block classification of the word address on the bottom-boot map.
    wire is_boot  = (word_addr < PARAM0_BASE);
    wire is_param = (word_addr >= PARAM0_BASE) && (word_addr <= PARAM_LAST);
    wire [5:0] small_idx = 6'(word_addr >> SMALL_SHIFT);
    wire [5:0] main_idx  = 6'((word_addr - MAIN0_BASE) >> MAIN_SHIFT);
    wire [5:0] block_kind = is_boot  ? small_idx :
                            is_param ? 6'(small_idx - 6'h02) : main_idx;

    // Next levels of the device pins: select and enable from where the sequencer goes next, write strobe and drivers from where it is now.
    wire              sel_next   = (state_next == ST_ACCESS);             // Select spans the whole access.
    wire              oe_next    = sel_next && (src_req.op == OP_READ);    // Only reads open the device drivers.
    // Write strobe falls one cycle into the access and rises one cycle before select does.
    wire              we_next    = in_access && is_write && !last_cycle && (cnt_reg != 8'h01);
    wire              drive_next = in_access && is_write;                  // Our drivers carry writes only.
    // Bus word to write: a mode command on the low byte, else the user's data.
    wire [DATA_W-1:0] wdata_next = (src_req.op == OP_MODE) ? {8'h00, mode_cmd} : src_req.wdata;

    // Handshake is combinational.
    assign req_ready = (state_reg == ST_IDLE);
    assign rsp_valid = rsp_reg;
    assign rsp_data  = rdata_reg;
    assign cur_mode  = mode_reg;

    // Next state of the sequencer.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            // Waiting; a reset request takes the reset phase, anything else a bus access.
            ST_IDLE: begin
                if (req_valid) begin
                    state_next = (req.op == OP_RESET) ? ST_RESET : ST_ACCESS;
                end
            end
            // Bus access of a fixed length, counted down in the phase counter.
            ST_ACCESS: begin
                if (last_cycle) begin
                    state_next = ST_DONE;
                end
            end
            // Device reset pin held low until the counter runs out.
            ST_RESET: begin
                if (last_cycle) begin
                    state_next = ST_DONE;
                end
            end
            // One cycle for the response pulse; select is already released.
            ST_DONE: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State and counter registers.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (req_ready && req_valid) begin
                // Load the phase length of the request just taken.
                cnt_reg <= (req.op == OP_RESET) ? reset_len : access_len;
            end else if (!last_cycle) begin
                // Count down and then rest at zero.
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    // Request capture.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_reg <= '0;
        end else if (req_ready && req_valid) begin
            cur_reg <= req;
        end
    end

    // Tracked device mode: array after power-up or device reset, else last mode command.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // The device comes up in array mode with no command.
            mode_reg <= MODE_ARRAY;
        end else if (in_reset && last_cycle) begin
            // Leaving the device reset puts it back in array mode.
            mode_reg <= MODE_ARRAY;
        end else if (in_access && last_cycle && cur_reg.op == OP_MODE) begin
            // A finished mode command becomes the mode that reads return.
            mode_reg <= cur_reg.mode;
        end
    end

    // Read data is sampled at the end of the access while select and enable are low.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= '0;
            rsp_reg   <= 1'b0;
        end else begin
            // Pulse for one cycle as a request finishes.
            rsp_reg <= (state_next == ST_DONE) && (state_reg != ST_DONE);
            if (in_access && last_cycle && is_read) begin
                // Byte mode carries data on the low lane only.
                rdata_reg <= byte_mode ? {8'h00, data_pins_in[7:0]} : data_pins_in;
            end
        end
    end

    // Registered control strobes; a plain bus cycle for every access, no supply control.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Deselected and idle, with the device reset pin released.
            ctl <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
                     reset_n: 1'b1, word_mode: 1'b1, protect_n: 1'b0};
        end else begin
            // Select only during an access; high floats the device data pins.
            ctl.chip_sel_n <= !sel_next;
            // Output enable only for reads, never with our own drivers on.
            ctl.out_en_n   <= !oe_next;
            // Write strobe low inside the access but released one cycle before select.
            ctl.write_n    <= !we_next;
            // Device reset low for the whole reset phase.
            ctl.reset_n    <= !(state_next == ST_RESET);
            ctl.word_mode  <= !byte_mode;
            ctl.protect_n  <= protect_n;
        end
    end

    // Registered address, write data and block index, valid from the edge a request is taken.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Address at zero and our data drivers off.
            addr_pins      <= '0;
            addr_low       <= 1'b0;
            data_pins_out  <= '0;
            data_pins_oe_n <= 1'b1;
            rsp_block_kind <= '0;
        end else begin
            addr_pins      <= word_addr;
            addr_low       <= byte_mode ? src_req.addr[0] : 1'b0;
            data_pins_out  <= wdata_next;
            // Drivers follow a write or mode command's access one cycle late, so they stay on through its done cycle.
            data_pins_oe_n <= !drive_next;
            rsp_block_kind <= block_kind;
        end
    end

endmodule

// ==== pkg/fbh_pkg.sv ====
// Package with constants and carrier types for the flash bus host controller.
package fbh_pkg;

    // Bus widths.
    localparam int WORD_ADDR_W = 21;
    localparam int BYTE_ADDR_W = 22;
    localparam int DATA_W      = 16;

    // Read-mode command codes written to the command interface.
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
    localparam logic [7:0] CMD_READ_IDENT  = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;

    // Status value expected after a device reset.
    localparam logic [7:0] STATUS_AFTER_RESET = 8'h80;

    // Bottom-boot word-address map.
    localparam logic [20:0] BOOT0_BASE  = 21'h000000;
    localparam logic [20:0] BOOT1_BASE  = 21'h001000;
    localparam logic [20:0] PARAM0_BASE = 21'h002000;
    localparam logic [20:0] PARAM_LAST  = 21'h007fff;
    localparam logic [20:0] MAIN0_BASE  = 21'h008000;
    localparam logic [20:0] MAIN62_BASE = 21'h1f8000;
    localparam int SMALL_SHIFT = 12;
    localparam int MAIN_SHIFT  = 15;

    // Timing: reset low time and access phase length.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int RESET_LOW_NS   = 100;
    localparam int RESET_CYCLES   = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_DEFAULT = 8;

    // Operation kinds requested by the user.
    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_MODE  = 2'b10,
        OP_RESET = 2'b11
    } fbh_op_type;

    // Read modes selected through the command interface.
    typedef enum logic [1:0] {
        MODE_ARRAY  = 2'b00,
        MODE_IDENT  = 2'b01,
        MODE_STATUS = 2'b10
    } fbh_mode_type;

    // A user request.
    typedef struct packed {
        fbh_op_type          op;
        fbh_mode_type        mode;
        logic [BYTE_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]   wdata;
    } fbh_req_type;

    // Control pin levels driven to the device (all active low except word_mode, high for word width).
    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_n;
        logic reset_n;
        logic word_mode;
        logic protect_n;
    } fbh_ctl_type;

endpackage

// ==== tb/fbh_host_asserts.sv ====
// Checker for the flash bus host controller pins.
module fbh_host_asserts
    import fbh_pkg::*;
#(
    parameter int ACCESS_CYCLES = ACCESS_DEFAULT
) (
    // Clock, reset and user side.
    input wire logic         core_clk,
    input wire logic         reset_n,
    input wire logic         req_valid,
    input wire logic         req_ready,
    input wire fbh_req_type  req,
    input wire logic         byte_mode,
    input wire logic         rsp_valid,
    input wire fbh_mode_type cur_mode,
    // Device pins.
    input wire fbh_ctl_type  ctl,
    input wire logic         addr_low,
    input wire logic         data_pins_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // An access answers one edge after its last access cycle.
    localparam int ANS = ACCESS_CYCLES + 1;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // A request is taken on this edge.
    wire take = req_valid && req_ready;
    wire take_rd = take && req.op == OP_READ;
    // The device reset pin stays low for ten cycles.
    sequence s_rst_low;
        (!ctl.reset_n)[*8] ##1 !ctl.reset_n ##1 !ctl.reset_n;
    endsequence
    a_no_contention: assert property (!data_pins_oe_n |-> ctl.out_en_n) else $error("bus contention");
    a_read_strobes: assert property (!ctl.out_en_n |-> ctl.write_n && ctl.reset_n) else $error("strobe in read");
    a_read_select: assert property (take_rd |=> !ctl.chip_sel_n && !ctl.out_en_n) else $error("no select");
    a_width_select: assert property (take_rd |=> ctl.word_mode == !$past(byte_mode)) else $error("width");
    a_byte_lane: assert property (take_rd && byte_mode |=> addr_low == $past(req.addr[0])) else $error("lane");
    a_answer_time: assert property (take && req.op != OP_RESET |-> ##ANS rsp_valid) else $error("late");
    a_reset_len: assert property ($fell(ctl.reset_n) |-> s_rst_low) else $error("short reset");
    a_reset_mode: assert property (take && req.op == OP_RESET |-> ##11 rsp_valid && cur_mode == MODE_ARRAY)
        else $error("reset mode");
    a_one_pulse: assert property (rsp_valid |=> !rsp_valid && req_ready) else $error("pulse");
endmodule
bind fbh_host fbh_host_asserts #(.ACCESS_CYCLES(ACCESS_CYCLES)) i_fbh_host_asserts (.core_clk, .reset_n,
    .req_valid, .req_ready, .req, .byte_mode, .rsp_valid, .cur_mode, .ctl, .addr_low, .data_pins_oe_n);

// ==== tb/fbh_flash_model.sv ====
// Behavioural model of the bottom-boot flash seen at its pins.
module fbh_flash_model
    import fbh_pkg::*;
#(
    parameter logic [15:0] ID_CODE = 16'h00c5 // Arbitrary identifier value.
) (
    // Control, address and data pins.
    input  wire fbh_ctl_type  ctl,
    input  wire logic [20:0]  addr_pins,
    input  wire logic         addr_low,
    input  wire logic [15:0]  data_pins_out,
    output logic [15:0]       data_pins_in
);
    timeunit 1ns;
    timeprecision 1ps;
    fbh_mode_type mode = MODE_ARRAY; // Power-up read mode.
    logic [15:0]  last = 16'h0000;   // Last level driven, inverted when floating.
    logic [6:0]   idx;               // Block index: boot 0-1, parameter 2-7, main 8-70.
    logic [15:0]  word;
    logic [15:0]  dq;
    wire drv = !ctl.chip_sel_n && !ctl.out_en_n && ctl.reset_n;
    assign idx = addr_pins < 21'h008000 ? {4'h0, addr_pins[14:12]} : {1'b0, addr_pins[20:15]} + 7'h07;
    assign word = mode == MODE_STATUS ? {8'h00, STATUS_AFTER_RESET} :
        mode == MODE_IDENT ? ID_CODE : {1'b0, idx, addr_pins[7:0]};
    assign dq = ctl.word_mode ? word : {word[15:8], addr_low ? word[15:8] : word[7:0]};
    assign data_pins_in = drv ? dq : ~last;
    always @(drv or dq) if (drv) last = dq;
    // Commands latch on the rising write strobe; reset restores array mode.
    always @(posedge ctl.write_n or negedge ctl.reset_n) begin
        if (!ctl.reset_n) mode = MODE_ARRAY;
        else if (!ctl.chip_sel_n && data_pins_out[7:0] == CMD_READ_ARRAY) mode = MODE_ARRAY;
        else if (!ctl.chip_sel_n && data_pins_out[7:0] == CMD_READ_IDENT) mode = MODE_IDENT;
        else if (!ctl.chip_sel_n && data_pins_out[7:0] == CMD_READ_STATUS) mode = MODE_STATUS;
    end
endmodule

// ==== tb/fbh_host_test.sv ====
// Self-checking testbench for the flash bus host controller.
module fbh_host_test
    import fbh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic byte_mode = 1'b0;
    fbh_req_type req = '0;
    logic req_ready, rsp_valid, addr_low, oe_n;
    logic [15:0] rsp_data, dq_out, dq_dev, dq_wire;
    logic [20:0] addr_pins;
    logic [5:0] blk_kind;
    fbh_mode_type cur_mode;
    fbh_ctl_type ctl;
    int error_cnt = 0;
    int check_count = 0;
    // The wire carries the host while it drives, else the device.
    assign dq_wire = !oe_n ? dq_out : dq_dev;
    fbh_host #(.ACCESS_CYCLES(4)) i_fbh_host (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .byte_mode(byte_mode), .protect_n(1'b1), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_block_kind(blk_kind), .cur_mode(cur_mode), .ctl(ctl), .addr_pins(addr_pins),
        .addr_low(addr_low), .data_pins_in(dq_wire), .data_pins_out(dq_out), .data_pins_oe_n(oe_n));
    fbh_flash_model i_fbh_flash_model (.ctl(ctl), .addr_pins(addr_pins), .addr_low(addr_low),
        .data_pins_out(dq_wire), .data_pins_in(dq_dev));
    initial forever #5 core_clk = ~core_clk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One request, held until taken, then a bounded wait for its answer.
    task automatic run(input fbh_op_type op, input fbh_mode_type md, input logic [21:0] a);
        int n;
        @(posedge core_clk);
        req <= '{op, md, a, 16'h0000};
        req_valid <= 1'b1;
        n = 0;
        do begin @(negedge core_clk); n++; end while (req_ready !== 1'b1 && n < 50);
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin @(negedge core_clk); n++; end while (rsp_valid !== 1'b1 && n < 50);
        if (rsp_valid !== 1'b1 || n == 50) begin error_cnt++; stop_test(); end
    endtask
    task automatic t_map();
        logic [21:0] a [6] = '{22'h000fff, 22'h001000, 22'h002000, 22'h007fff, 22'h008000, 22'h1f8000};
        logic [15:0] e [6] = '{16'h00ff, 16'h0100, 16'h0200, 16'h07ff, 16'h0800, 16'h4600};
        logic [15:0] k [6] = '{16'h0000, 16'h0001, 16'h0000, 16'h0005, 16'h0000, 16'h003e};
        for (int i = 0; i < 6; i++) begin
            run(OP_READ, MODE_ARRAY, a[i]);
            chk(rsp_data, e[i]);
            chk({10'h000, blk_kind}, k[i]);
        end
        $display("map test done");
    endtask
    task automatic t_modes();
        fbh_mode_type m [3] = '{MODE_STATUS, MODE_IDENT, MODE_ARRAY};
        logic [15:0] e [3] = '{16'h0080, 16'h00c5, 16'h0100};
        for (int i = 0; i < 3; i++) begin
            run(OP_MODE, m[i], 22'h000000);
            run(OP_READ, MODE_ARRAY, 22'h001000);
            chk(rsp_data, e[i]);
        end
        $display("mode test done");
    endtask
    task automatic t_byte();
        @(posedge core_clk);
        byte_mode <= 1'b1;
        run(OP_READ, MODE_ARRAY, 22'h002001);
        chk(rsp_data, 16'h0001);
        chk({10'h000, blk_kind}, 16'h0001);
        run(OP_READ, MODE_ARRAY, 22'h00fffe);
        chk(rsp_data, 16'h00ff);
        chk({10'h000, blk_kind}, 16'h0005);
        @(posedge core_clk);
        byte_mode <= 1'b0;
        $display("byte test done");
    endtask
    task automatic t_reset();
        run(OP_MODE, MODE_STATUS, 22'h000000);
        run(OP_RESET, MODE_ARRAY, 22'h000000);
        chk({14'h0000, cur_mode}, 16'h0000);
        run(OP_READ, MODE_ARRAY, 22'h008000);
        chk(rsp_data, 16'h0800);
        $display("reset test done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        t_map();
        t_modes();
        t_byte();
        t_reset();
        stop_test();
    end
endmodule
